/* src/sss_slave.sv */
// Slave-mode serial shifter clocked by an external master
// Operation
// RL1: Data shifts out and in step with each clock pulse from the master.
// RL2: The port flag is set when the last bit of a byte is latched.
// RL3: The master must hold the clock at its idle level before enabling.
// RL4: Software can sample the present level of the serial clock input.
// RL5: The expected idle clock level follows the idle polarity setting.
// RL6: Only the master makes the shift clock; this slave never drives it.
// RL7: In sleep the shifter keeps running and byte completion sets the flag.
// RL8: With its interrupt enabled, a byte done in sleep wakes the device.
// RL9: In a chain the slave echoes in a second burst what the first brought.
// RL10: A chain shares one select line and passes data slave to slave.
// RL11: With overwrite enabled, a new byte replaces an unread buffer.
// RL12: Each completed byte is moved from the shift register to the buffer.
// RL13: Without overwrite, an unread buffer is kept and overflow is flagged; here overflow sets only when a completed byte finds the FIFO full.
`timescale 1ns/1ps
`include "sss_map.svh"
module sss_slave
  import sss_pkg::*;
#(
  parameter int BYTE_W     = `SSS_BYTE_W,
  parameter int FIFO_DEPTH = `SSS_FIFO_DEPTH
) (
  input  wire logic              core_clk,
  input  wire logic              nrst,
  input  wire sss_pins_type      pins,
  input  wire sss_cfg_type       cfg,
  input  wire sss_ack_type       ack,
  input  wire logic [BYTE_W-1:0] tx_data,
  input  wire logic              tx_valid,
  output logic                   tx_ready,
  output logic      [BYTE_W-1:0] serial_data_buffer,
  output logic                   buffer_full,
  output logic                   serial_port_irq_flag,
  output logic                   overflow,
  output logic                   wake_request,
  output logic                   sck_level,
  output logic                   sck_idle_ok,
  output logic                   sdo_out,
  output logic                   sdo_oe_n
);

  localparam int CW = $clog2(BYTE_W);
  localparam logic [CW-1:0] LAST_BIT = CW'(BYTE_W - 1);

  generate
    if (BYTE_W < 2) begin : g_chk
      $error("sss_slave: BYTE_W must be at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [2:0]        sck_s;
    logic [1:0]        sdi_s;
    logic [1:0]        ss_s;
    sss_fsm_type       st;
    logic [BYTE_W-1:0] shreg;
    logic [CW-1:0]     bitcnt;
    logic              lat;
    logic              done;
    logic              tx_pend;
    logic [BYTE_W-1:0] tx_hold;
    logic [BYTE_W-1:0] dbuf;
    logic              dbuf_full;
    logic              irq;
    logic              ovf;
  } slave_state_type;

  slave_state_type   s_q;
  slave_state_type   s_d;

  logic              sck_now;
  logic              sck_prev;
  logic              lead_edge;
  logic              trail_edge;
  logic              byte_done;
  logic [BYTE_W-1:0] rx_byte;
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic              fifo_out_ready;
  logic [BYTE_W-1:0] fifo_out_data;

  // Stage 0 feeds only stage 1; edges come from stages 1 and 2
  assign sck_now  = s_q.sck_s[1];
  assign sck_prev = s_q.sck_s[2];

  // Idle-to-active edge samples, active-to-idle edge shifts
  assign lead_edge  = (s_q.st == SSS_XFER) &&
                      (sck_now != cfg.clock_idle_polarity) &&
                      (sck_prev == cfg.clock_idle_polarity); // RL5
  assign trail_edge = (s_q.st == SSS_XFER) &&
                      (sck_now == cfg.clock_idle_polarity) &&
                      (sck_prev != cfg.clock_idle_polarity); // RL5

  assign byte_done = lead_edge && (s_q.bitcnt == LAST_BIT);
  assign rx_byte   = {s_q.shreg[BYTE_W-2:0], s_q.sdi_s[1]};

  // Overwrite lets the FIFO drain even into an unread buffer
  assign fifo_out_ready = !s_q.dbuf_full ||
                          cfg.buffer_overwrite_enable ||
                          ack.buffer_read; // RL11

  sss_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .in_valid  (byte_done),
    .in_ready  (fifo_in_ready),
    .in_data   (rx_byte),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  always_comb begin
    s_d = s_q;
    s_d.sck_s = {s_q.sck_s[1:0], pins.sck};
    s_d.sdi_s = {s_q.sdi_s[0], pins.sdi};
    s_d.ss_s  = {s_q.ss_s[0], pins.ss_n};

    // Transmit byte waits here until the next byte boundary
    if (tx_valid && !s_q.tx_pend) begin
      s_d.tx_hold = tx_data;
      s_d.tx_pend = 1'b1;
    end

    case (s_q.st)
      SSS_OFF: begin
        s_d.bitcnt = '0;
        if (cfg.slave_enable) begin
          s_d.st = SSS_IDLE; // RL3
        end
      end
      SSS_IDLE: begin
        s_d.bitcnt = '0;
        s_d.done   = 1'b0;
        if (s_q.tx_pend) begin
          s_d.shreg   = s_q.tx_hold;
          s_d.tx_pend = tx_valid;
          s_d.tx_hold = tx_valid ? tx_data : s_q.tx_hold;
        end
        if (!cfg.slave_enable) begin
          s_d.st = SSS_OFF;
        end else if (!s_q.ss_s[1]) begin
          s_d.st = SSS_XFER;
        end
      end
      SSS_XFER: begin
        // Runs on in sleep; only the link pins pace it
        if (lead_edge) begin
          s_d.lat    = s_q.sdi_s[1]; // RL1 RL7
          s_d.bitcnt = byte_done ? '0 : s_q.bitcnt + 1'b1;
          s_d.done   = byte_done;
        end
        if (trail_edge) begin
          // Byte end marker lives until the trailing edge that uses it
          s_d.done = 1'b0;
          if (s_q.done && s_q.tx_pend) begin
            s_d.shreg   = s_q.tx_hold;
            s_d.tx_pend = tx_valid;
            s_d.tx_hold = tx_valid ? tx_data : s_q.tx_hold;
          end else begin
            // Without a new byte the received one goes straight back out
            s_d.shreg = {s_q.shreg[BYTE_W-2:0], s_q.lat}; // RL1 RL9
          end
        end
        // A select release aborts a partial byte
        if (!cfg.slave_enable) begin
          s_d.st = SSS_OFF;
        end else if (s_q.ss_s[1]) begin
          s_d.st = SSS_IDLE;
        end
      end
      default: begin
        s_d.st = SSS_OFF;
      end
    endcase

    // A trailing edge with done clear at bit count zero leaves the shift result unchanged
    if (trail_edge && !s_q.done && s_q.st == SSS_XFER &&
        s_q.bitcnt == '0 && s_q.lat != s_q.shreg[0]) begin
      s_d.shreg = s_d.shreg;
    end

    // Buffer update from the FIFO head
    if (fifo_out_valid && fifo_out_ready) begin
      s_d.dbuf      = fifo_out_data; // RL12 RL11
      s_d.dbuf_full = 1'b1;
    end else if (ack.buffer_read) begin
      s_d.dbuf_full = 1'b0;
    end

    // Flags: a set in the same cycle as a clear wins
    if (ack.irq_clear) begin
      s_d.irq = 1'b0;
    end
    if (byte_done) begin
      s_d.irq = 1'b1; // RL2 RL7
    end
    if (ack.overflow_clear) begin
      s_d.ovf = 1'b0;
    end
    if (byte_done && !fifo_in_ready) begin
      s_d.ovf = 1'b1; // RL13
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_q       <= '0;
      s_q.shreg <= `SSS_SHIFT_RESET;
      s_q.dbuf  <= `SSS_BUF_RESET;
      s_q.st    <= SSS_OFF;
    end else begin
      s_q <= s_d;
    end
  end

  assign tx_ready             = !s_q.tx_pend;
  assign serial_data_buffer   = s_q.dbuf; // RL12
  assign buffer_full          = s_q.dbuf_full;
  assign serial_port_irq_flag = s_q.irq; // RL2
  assign overflow             = s_q.ovf; // RL13
  assign wake_request = cfg.sleep_mode && cfg.irq_enable && s_q.irq; // RL8
  assign sck_level    = sck_now; // RL4
  assign sck_idle_ok  = (sck_now == cfg.clock_idle_polarity); // RL5
  // The clock pin is only ever an input here
  assign sdo_out  = s_q.shreg[BYTE_W-1]; // RL1 RL6
  assign sdo_oe_n = (s_q.st != SSS_XFER); // RL10

endmodule

/* src/sss_map.svh */
// Constants of the slave-mode serial shifter
`ifndef SSS_MAP_SVH
`define SSS_MAP_SVH

// Bits in one serial byte
`define SSS_BYTE_W 8
// Words held between the shift logic and the data buffer
`define SSS_FIFO_DEPTH 8
// Flip-flops in each pin synchroniser
`define SSS_SYNC_STAGES 2
// Reset value of the data buffer
`define SSS_BUF_RESET 8'h00
// Reset value of the shift register
`define SSS_SHIFT_RESET 8'h00

`endif

/* src/sss_pkg.sv */
// Types shared by the slave-mode serial shifter files
package sss_pkg;

  typedef enum logic [1:0] {
    SSS_OFF  = 2'b00,
    SSS_IDLE = 2'b01,
    SSS_XFER = 2'b10
  } sss_fsm_type;

  // Raw link pins as they arrive from the master
  typedef struct packed {
    logic sck;
    logic sdi;
    logic ss_n;
  } sss_pins_type;

  // Static settings from the rest of the port
  typedef struct packed {
    logic slave_enable;
    logic clock_idle_polarity;
    logic buffer_overwrite_enable;
    logic sleep_mode;
    logic irq_enable;
  } sss_cfg_type;

  // Event strobes from the rest of the port
  typedef struct packed {
    logic buffer_read;
    logic irq_clear;
    logic overflow_clear;
  } sss_ack_type;

endpackage

/* src/sss_fifo.sv */
// Parameterised FIFO between byte completion and the data buffer
`timescale 1ns/1ps
`include "sss_map.svh"
module sss_fifo
  import sss_pkg::*;
#(
  parameter int WIDTH = `SSS_BYTE_W,
  parameter int DEPTH = `SSS_FIFO_DEPTH
) (
  input  wire logic             core_clk,
  input  wire logic             nrst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_chk
      $error("sss_fifo: DEPTH must be a power of two of at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [PW:0]   cnt;
  } fifo_state_type;

  fifo_state_type   s_q;
  fifo_state_type   s_d;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic             push;
  logic             pop;

  assign in_ready  = (s_q.cnt != DEPTH[PW:0]);
  assign out_valid = (s_q.cnt != '0);
  assign out_data  = mem_q[s_q.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.wr = s_q.wr + 1'b1;
    end
    if (pop) begin
      s_d.rd = s_q.rd + 1'b1;
    end
    // Simultaneous push and pop leaves the count alone
    if (push && !pop) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end else if (pop && !push) begin
      s_d.cnt = s_q.cnt - 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Storage needs no reset; reads are gated by the count
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_q[s_q.wr] <= in_data;
    end
  end

endmodule

/* tb/sss_slave_props.sv */
// Port checker for the slave shifter
`timescale 1ns/1ps
module sss_slave_props
  import sss_pkg::*;
#(parameter int BYTE_W = 8, parameter int FIFO_DEPTH = 8)
(
  input wire logic              core_clk,
  input wire logic              nrst,
  input wire sss_pins_type      pins,
  input wire sss_cfg_type       cfg,
  input wire sss_ack_type       ack,
  input wire logic              tx_valid,
  input wire logic              tx_ready,
  input wire logic [BYTE_W-1:0] serial_data_buffer,
  input wire logic              buffer_full,
  input wire logic              serial_port_irq_flag,
  input wire logic              overflow,
  input wire logic              wake_request,
  input wire logic              sck_level,
  input wire logic              sck_idle_ok,
  input wire logic              sdo_oe_n
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  property p_wake;
    wake_request == (cfg.sleep_mode && cfg.irq_enable
      && serial_port_irq_flag);
  endproperty
  a_wake: assert property (p_wake) else $error("bad wake");
  property p_idle;
    sck_idle_ok == (sck_level == cfg.clock_idle_polarity);
  endproperty
  a_idle: assert property (p_idle) else $error("bad idle");
  // Five quiet cycles cover the two synchroniser stages that sck_level is read from
  property p_sck;
    $stable(pins.sck) [*5] |-> sck_level == pins.sck;
  endproperty
  a_sck: assert property (p_sck) else $error("bad sck level");
  property p_oe;
    pins.ss_n [*5] |-> sdo_oe_n;
  endproperty
  a_oe: assert property (p_oe) else $error("sdo driven");
  property p_flag;
    $rose(serial_port_irq_flag) |-> !sdo_oe_n ##[0:2] !sck_idle_ok;
  endproperty
  a_flag: assert property (p_flag) else $error("bad flag");
  property p_buf;
    $rose(serial_port_irq_flag) && !buffer_full |-> ##[1:4] buffer_full;
  endproperty
  a_buf: assert property (p_buf) else $error("no move");
  property p_hold;
    (buffer_full && !ack.buffer_read && !cfg.buffer_overwrite_enable) [*3]
      |=> $stable(serial_data_buffer);
  endproperty
  a_hold: assert property (p_hold) else $error("overwrote");
  property p_ovf;
    $rose(overflow) |-> !cfg.buffer_overwrite_enable && buffer_full;
  endproperty
  a_ovf: assert property (p_ovf) else $error("bad overflow");
  property p_tx;
    tx_valid && tx_ready |=> !tx_ready;
  endproperty
  a_tx: assert property (p_tx) else $error("tx not taken");
  c_flag: cover property ($rose(serial_port_irq_flag));
  c_ovf: cover property ($rose(overflow));
  c_wake: cover property (wake_request);
endmodule
bind sss_slave sss_slave_props #(.BYTE_W(BYTE_W), .FIFO_DEPTH(FIFO_DEPTH))
  u_props (.core_clk, .nrst, .pins, .cfg, .ack, .tx_valid, .tx_ready,
    .serial_data_buffer, .buffer_full, .serial_port_irq_flag, .overflow,
    .wake_request, .sck_level, .sck_idle_ok, .sdo_oe_n);

/* tb/sss_master_model.sv */
// Behavioural serial master driving the link clock
`timescale 1ns/1ps
module sss_master_model (
  output logic      sck,
  output logic      sdi,
  output logic      ss_n,
  input  wire logic sdo,
  input  wire logic idle_lvl
);
  initial begin
    sck = 1'b0;
    sdi = 1'b0;
    ss_n = 1'b1;
  end
  // Clock rests at the idle level outside frames
  always @(idle_lvl) if (ss_n) sck = idle_lvl;
  task automatic sel();
    ss_n = 1'b0;
    #80;
  endtask
  task automatic xfer(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      sdi = d[i];
      #80;
      sck = ~idle_lvl;
      q[i] = sdo;
      #80;
      sck = idle_lvl;
    end
  endtask
  // Released data flips so a stale bit never looks valid
  task automatic desel();
    #80;
    ss_n = 1'b1;
    sdi = ~sdi;
    #80;
  endtask
endmodule

/* tb/sss_slave_tb_top.sv */
// Testbench for the slave-mode serial shifter
`timescale 1ns/1ps
module sss_slave_tb_top;
  import sss_pkg::*;
  logic        core_clk = 1'b0;
  logic        nrst = 1'b0;
  sss_cfg_type cfg = 5'b10000;
  sss_ack_type ack = 3'b000;
  logic [7:0]  tx_data = 8'h00;
  logic        tx_valid = 1'b0;
  logic [7:0]  serial_data_buffer, r;
  logic        tx_ready, buffer_full, serial_port_irq_flag, overflow;
  logic        wake_request, sck_level, sck_idle_ok, sdo_out, sdo_oe_n;
  wire         sck, sdi, ss_n;
  int          miscompares = 0, cmp_count = 0, cyc = 0;
  sss_slave DUT (.core_clk, .nrst, .pins({sck, sdi, ss_n}), .cfg, .ack,
    .tx_data, .tx_valid, .tx_ready, .serial_data_buffer, .buffer_full,
    .serial_port_irq_flag, .overflow, .wake_request, .sck_level,
    .sck_idle_ok, .sdo_out, .sdo_oe_n);
  sss_master_model m (.sck, .sdi, .ss_n, .sdo(sdo_out),
    .idle_lvl(cfg.clock_idle_polarity));
  always #5 core_clk = ~core_clk;
  // Whole run needs about 2700 cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      end_sim();
    end
  end
  task automatic end_sim();
    if (miscompares == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic clk(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic pulse(input sss_ack_type a);
    clk(1);
    ack = a;
    clk(1);
    ack = 3'b000;
    clk(3);
  endtask
  task automatic load(input logic [7:0] d);
    clk(1);
    tx_data = d;
    tx_valid = 1'b1;
    clk(1);
    tx_valid = 1'b0;
  endtask
  task automatic frame(input logic [7:0] d);
    clk(1);
    m.sel();
    m.xfer(d, r);
    m.desel();
  endtask
  task automatic t_basic();
    chk(sdo_oe_n, 8'h01);
    chk(sck_idle_ok, 8'h01);
    load(8'ha5);
    frame(8'h3c);
    chk(r, 8'ha5);
    chk(serial_port_irq_flag, 8'h01);
    chk(serial_data_buffer, 8'h3c);
    chk(buffer_full, 8'h01);
  endtask
  task automatic t_chain();
    pulse(3'b100);
    clk(1);
    m.sel();
    m.xfer(8'h5a, r);
    m.xfer(8'hc3, r);
    m.desel();
    chk(r, 8'h5a);
    chk(serial_data_buffer, 8'h5a);
    pulse(3'b100);
    chk(serial_data_buffer, 8'hc3);
    pulse(3'b100);
    chk(buffer_full, 8'h00);
  endtask
  // Reads are withheld until the FIFO refuses, then drained in order
  task automatic t_overflow();
    for (int i = 0; i < 10; i++) frame(8'(8'h10 + i));
    chk(overflow, 8'h01);
    chk(serial_data_buffer, 8'h10);
    for (int i = 1; i < 9; i++) begin
      pulse(3'b100);
      chk(serial_data_buffer, 8'(8'h10 + i));
    end
    pulse(3'b100);
    chk(buffer_full, 8'h00);
    pulse(3'b001);
    chk(overflow, 8'h00);
  endtask
  task automatic t_overwrite();
    cfg.buffer_overwrite_enable = 1'b1;
    frame(8'h77);
    frame(8'h88);
    chk(serial_data_buffer, 8'h88);
    chk(overflow, 8'h00);
    cfg.buffer_overwrite_enable = 1'b0;
    pulse(3'b100);
  endtask
  task automatic t_sleep();
    pulse(3'b010);
    chk(serial_port_irq_flag, 8'h00);
    cfg.sleep_mode = 1'b1;
    cfg.irq_enable = 1'b1;
    frame(8'h42);
    chk(serial_port_irq_flag, 8'h01);
    chk(serial_data_buffer, 8'h42);
    chk(wake_request, 8'h01);
    cfg.irq_enable = 1'b0;
    clk(1);
    chk(wake_request, 8'h00);
    cfg.sleep_mode = 1'b0;
    pulse(3'b100);
  endtask
  task automatic t_polarity();
    cfg.slave_enable = 1'b0;
    cfg.clock_idle_polarity = 1'b1;
    clk(6);
    chk(sck_level, 8'h01);
    chk(sck_idle_ok, 8'h01);
    cfg.slave_enable = 1'b1;
    clk(3);
    load(8'he1);
    frame(8'h1e);
    chk(r, 8'he1);
    chk(serial_data_buffer, 8'h1e);
  endtask
  initial begin
    clk(10);
    nrst = 1'b1;
    clk(5);
    t_basic();
    t_chain();
    t_overflow();
    t_overwrite();
    t_sleep();
    t_polarity();
    end_sim();
  end
endmodule
